/* File: design/uael_pkg.sv */
// package: register map, field layout and timing constants for the alarm logger
`default_nettype none
package uael_pkg;
  // axi4-lite byte addresses
  localparam logic [8:0] UAEL_ADDR_CMD = 9'h000;
  localparam logic [8:0] UAEL_ADDR_CTRL = 9'h004;
  localparam logic [8:0] UAEL_ADDR_STATUS = 9'h008;
  localparam logic [8:0] UAEL_ADDR_ERR_CODE = 9'h00c;
  localparam logic [8:0] UAEL_ADDR_LOG_PTR = 9'h010;
  localparam logic [8:0] UAEL_ADDR_SIM_NUM = 9'h014;
  localparam logic [8:0] UAEL_ADDR_FPD_TIME = 9'h018;
  localparam logic [8:0] UAEL_ADDR_FPD_CFG = 9'h01c;
  localparam logic [8:0] UAEL_ADDR_DIAG = 9'h020;
  localparam logic [8:0] UAEL_ADDR_SYSERR = 9'h024;
  localparam logic [8:0] UAEL_ADDR_FLAGS = 9'h040;
  localparam logic [8:0] UAEL_ADDR_LOG = 9'h080;
  // command word fields (write-only, self clearing)
  localparam int UAEL_CMD_NUM_LSB = 0;
  localparam int UAEL_CMD_NONFATAL = 16;
  localparam int UAEL_CMD_FATAL = 17;
  localparam int UAEL_CMD_CLEAR = 18;
  localparam int UAEL_CMD_FPD_START = 19;
  localparam int UAEL_CMD_SYS_NONFATAL = 20;
  localparam int UAEL_CMD_SYS_FATAL = 21;
  // control word fields
  localparam int UAEL_CTRL_PTR_RST = 0;
  localparam int UAEL_CTRL_TEACH = 1;
  localparam int UAEL_CTRL_NO_LOG = 15;
  localparam logic [15:0] UAEL_CTRL_RESET = 16'h0000;
  // status bits
  localparam int UAEL_ST_NONFATAL = 0;
  localparam int UAEL_ST_FATAL = 1;
  localparam int UAEL_ST_HALT = 2;
  localparam int UAEL_ST_CARRY = 3;
  localparam int UAEL_ST_FPD_BUSY = 4;
  // fpd config fields
  localparam int UAEL_FCFG_NUM_LSB = 0;
  localparam int UAEL_FCFG_ALARM_EN = 16;
  localparam int UAEL_FCFG_MSG_DIAG = 17;
  // error codes
  localparam logic [15:0] UAEL_CODE_NONFATAL_BASE = 16'h4100;
  localparam logic [15:0] UAEL_CODE_FATAL_BASE = 16'hc100;
  // simulation number window
  localparam logic [15:0] UAEL_SIM_MIN = 16'h0001;
  localparam logic [15:0] UAEL_SIM_MAX = 16'h01ff;
  // log and flag geometry
  localparam int UAEL_LOG_DEPTH = 20;
  localparam int UAEL_NUM_FLAGS = 512;
  // timing
  localparam int UAEL_CLK_HZ = 10_000_000;
  localparam int UAEL_TICK_US = 100;
  localparam int UAEL_TICK_CYC = UAEL_CLK_HZ / 1_000_000 * UAEL_TICK_US;
  localparam int UAEL_BLINK_TICKS = 2500;
  localparam logic [15:0] UAEL_FPD_TIME_RESET = 16'h0064;
  typedef enum logic [1:0] {
    UAEL_FPD_IDLE = 2'b00,
    UAEL_FPD_RUN = 2'b01,
    UAEL_FPD_DONE = 2'b10
  } uael_fpd_state_t;
endpackage
`default_nettype wire

/* File: design/uael_logger.sv */
// user alarm raising, error flags, per-number flags, error log and fpd unit
//
// Operation
// - nonfatal continues, fatal halts execution
// - set flag, code word, log, indicator
// - set flag bit for executed alarm number
// - number 00 or clear command clears nonfatal
// - fpd timer sets carry on timeout
// - timeout optionally raises numbered nonfatal alarm
// - diagnosis reports blocking input bit address
// - teaching stores measured time as monitor time
// - log holds latest 20 records
// - pointer increments by one per record
// - pointer reset bit clears pointer
// - sim word 0001..01ff selects number
// - sim number raises given system error
// - sim errors cleared like real, reset
// - storage setting bit 15 suppresses user nonfatal logging, not sim nonfatal
// - suppressed alarms still update flags, code
// - suppression never affects other error logging
// - full log drops oldest, shifts, appends
// - pointer stops at 20 records
`default_nettype none
module uael_logger
  import uael_pkg::*;
#(
  parameter int DIAG_W = 16,
  parameter int BLINK_TICKS = UAEL_BLINK_TICKS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [8:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [8:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic diag_out,
  input wire logic [DIAG_W-1:0] diag_inputs,
  output logic err_led,
  output logic prog_halt,
  output logic fpd_carry
);
  // ==========================================================
  // reset release and pin synchronisers
  logic rst_meta_reg, rst_n_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end
  logic dout_meta_reg, dout_reg;
  logic [DIAG_W-1:0] din_meta_reg, din_reg;
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dout_meta_reg <= 1'b0;
      dout_reg <= 1'b0;
      din_meta_reg <= '0;
      din_reg <= '0;
    end else begin
      dout_meta_reg <= diag_out;
      dout_reg <= dout_meta_reg;
      din_meta_reg <= diag_inputs;
      din_reg <= din_meta_reg;
    end
  end
  // ==========================================================
  // axi4-lite write channel
  logic aw_hold_reg, w_hold_reg;
  logic [8:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_go;
  assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_reg <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign s_axi_bresp = 2'b00;
  // ==========================================================
  // software registers
  logic [15:0] ctrl_reg, simulation_alarm_number_reg, fpd_time_reg;
  logic [31:0] fpd_cfg_reg, cmd_pulse, syserr_reg;
  logic wr_cmd;
  assign wr_cmd = wr_go && awaddr_reg == UAEL_ADDR_CMD && wstrb_reg == 4'hf;
  assign cmd_pulse = wr_cmd ? wdata_reg : 32'h0000_0000;
  logic teach_store;
  logic [15:0] teach_val;
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_reg <= UAEL_CTRL_RESET;
      simulation_alarm_number_reg <= 16'h0000;
      fpd_time_reg <= UAEL_FPD_TIME_RESET;
      fpd_cfg_reg <= '0;
      syserr_reg <= '0;
    end else begin
      if (wr_go && awaddr_reg == UAEL_ADDR_CTRL) begin
        ctrl_reg <= wdata_reg[15:0];
      end else begin
        ctrl_reg[UAEL_CTRL_PTR_RST] <= 1'b0;
      end
      if (wr_go && awaddr_reg == UAEL_ADDR_SIM_NUM)
        simulation_alarm_number_reg <= wdata_reg[15:0];
      if (wr_go && awaddr_reg == UAEL_ADDR_FPD_CFG)
        fpd_cfg_reg <= wdata_reg;
      if (wr_go && awaddr_reg == UAEL_ADDR_SYSERR)
        syserr_reg <= wdata_reg;
      if (teach_store) begin
        fpd_time_reg <= teach_val;
      end else if (wr_go && awaddr_reg == UAEL_ADDR_FPD_TIME) begin
        fpd_time_reg <= wdata_reg[15:0];
      end
    end
  end
  // ==========================================================
  // failure-point detector
  uael_fpd_state_t fpd_state_reg;
  logic [15:0] fpd_cnt_reg;
  logic [9:0] tick_cnt_reg;
  logic tick;
  logic fpd_timeout;
  logic [15:0] diag_addr_reg;
  assign tick = tick_cnt_reg == 10'(UAEL_TICK_CYC - 1);
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? 10'h000 : tick_cnt_reg + 10'h001;
    end
  end
  assign fpd_timeout = fpd_state_reg == UAEL_FPD_RUN && !dout_reg &&
    !ctrl_reg[UAEL_CTRL_TEACH] && tick && fpd_cnt_reg + 16'h0001 >= fpd_time_reg;
  assign teach_store = fpd_state_reg == UAEL_FPD_RUN && dout_reg &&
    ctrl_reg[UAEL_CTRL_TEACH];
  assign teach_val = fpd_cnt_reg;
  // lowest input that is still off is taken as the blocking one
  logic [15:0] blk_idx;
  always_comb begin
    blk_idx = 16'hffff;
    for (int i = DIAG_W - 1; i >= 0; i--) begin
      if (!din_reg[i]) blk_idx = 16'(i);
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fpd_state_reg <= UAEL_FPD_IDLE;
      fpd_cnt_reg <= '0;
      fpd_carry <= 1'b0;
      diag_addr_reg <= '0;
    end else begin
      case (fpd_state_reg)
        UAEL_FPD_IDLE: begin
          if (cmd_pulse[UAEL_CMD_FPD_START]) begin
            fpd_state_reg <= UAEL_FPD_RUN;
            fpd_cnt_reg <= '0;
            fpd_carry <= 1'b0;
          end
        end
        UAEL_FPD_RUN: begin
          if (dout_reg) begin
            fpd_state_reg <= UAEL_FPD_DONE;
          end else if (fpd_timeout) begin
            fpd_carry <= 1'b1;
            diag_addr_reg <= blk_idx;
            fpd_state_reg <= UAEL_FPD_DONE;
          end else if (tick && fpd_cnt_reg != 16'hffff) begin
            fpd_cnt_reg <= fpd_cnt_reg + 16'h0001;
          end
        end
        UAEL_FPD_DONE: begin
          if (cmd_pulse[UAEL_CMD_FPD_START]) begin
            fpd_state_reg <= UAEL_FPD_RUN;
            fpd_cnt_reg <= '0;
            fpd_carry <= 1'b0;
          end
        end
        default: fpd_state_reg <= UAEL_FPD_IDLE;
      endcase
    end
  end
  // ==========================================================
  // alarm decode
  logic [8:0] cmd_num, alarm_num;
  logic is_sim, nf_go, f_go, nf_clr, raise, do_log, user_nf;
  logic [15:0] code_in;
  assign cmd_num = cmd_pulse[8:0];
  assign is_sim = simulation_alarm_number_reg >= UAEL_SIM_MIN &&
    simulation_alarm_number_reg <= UAEL_SIM_MAX &&
    {7'h00, cmd_num} == simulation_alarm_number_reg;
  assign nf_clr = cmd_pulse[UAEL_CMD_NONFATAL] && cmd_num == 9'h000;
  assign nf_go = (cmd_pulse[UAEL_CMD_NONFATAL] && !nf_clr) ||
    (fpd_timeout && fpd_cfg_reg[UAEL_FCFG_ALARM_EN]);
  assign f_go = cmd_pulse[UAEL_CMD_FATAL];
  assign raise = nf_go || f_go;
  assign alarm_num = cmd_pulse[UAEL_CMD_NONFATAL] || f_go ? cmd_num :
    fpd_cfg_reg[8:0];
  assign user_nf = nf_go && !f_go && !is_sim;
  always_comb begin
    if (is_sim && f_go)
      code_in = syserr_reg[31:16];
    else if (is_sim)
      code_in = syserr_reg[15:0];
    else if (f_go)
      code_in = UAEL_CODE_FATAL_BASE | {7'h00, alarm_num};
    else
      code_in = UAEL_CODE_NONFATAL_BASE | {7'h00, alarm_num};
  end
  assign do_log = raise && !(user_nf && ctrl_reg[UAEL_CTRL_NO_LOG]);
  // ==========================================================
  // flags, code word, per-number flags
  logic nf_flag_reg, f_flag_reg, sys_clr;
  logic [15:0] error_code_word_reg;
  logic [UAEL_NUM_FLAGS-1:0] executed_alarm_number_flags_reg;
  assign sys_clr = cmd_pulse[UAEL_CMD_CLEAR];
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      nf_flag_reg <= 1'b0;
      f_flag_reg <= 1'b0;
      prog_halt <= 1'b0;
      error_code_word_reg <= '0;
      executed_alarm_number_flags_reg <= '0;
    end else begin
      if (nf_go && !f_go) begin
        nf_flag_reg <= 1'b1;
      end else if (nf_clr || sys_clr) begin
        nf_flag_reg <= 1'b0;
      end
      if (f_go) begin
        f_flag_reg <= 1'b1;
        prog_halt <= 1'b1;
      end else if (sys_clr) begin
        f_flag_reg <= 1'b0;
        prog_halt <= 1'b0;
      end
      if (raise) begin
        error_code_word_reg <= code_in;
        executed_alarm_number_flags_reg[alarm_num] <= 1'b1;
      end else if (sys_clr) begin
        executed_alarm_number_flags_reg <= '0;
      end
    end
  end
  // ==========================================================
  // error log: code, detail and timestamp per record
  logic [15:0] log_code [UAEL_LOG_DEPTH];
  logic [15:0] log_info [UAEL_LOG_DEPTH];
  logic [31:0] log_time [UAEL_LOG_DEPTH];
  logic [15:0] error_log_pointer_reg;
  logic [31:0] time_reg;
  logic [15:0] info_in;
  assign info_in = fpd_timeout && fpd_cfg_reg[UAEL_FCFG_MSG_DIAG] ?
    blk_idx : {7'h00, alarm_num};
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      time_reg <= '0;
    end else if (tick) begin
      time_reg <= time_reg + 32'h0000_0001;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      error_log_pointer_reg <= '0;
    end else if (ctrl_reg[UAEL_CTRL_PTR_RST]) begin
      error_log_pointer_reg <= 16'h0000;
    end else if (do_log &&
      error_log_pointer_reg < 16'(UAEL_LOG_DEPTH)) begin
      error_log_pointer_reg <= error_log_pointer_reg + 16'h0001;
    end
  end
  // storage has no reset; the pointer says which slots are valid
  always_ff @(posedge ref_clk) begin
    if (do_log) begin
      if (error_log_pointer_reg >= 16'(UAEL_LOG_DEPTH)) begin
        for (int i = 0; i < UAEL_LOG_DEPTH - 1; i++) begin
          log_code[i] <= log_code[i+1];
          log_info[i] <= log_info[i+1];
          log_time[i] <= log_time[i+1];
        end
        log_code[UAEL_LOG_DEPTH-1] <= code_in;
        log_info[UAEL_LOG_DEPTH-1] <= info_in;
        log_time[UAEL_LOG_DEPTH-1] <= time_reg;
      end else begin
        log_code[error_log_pointer_reg[4:0]] <= code_in;
        log_info[error_log_pointer_reg[4:0]] <= info_in;
        log_time[error_log_pointer_reg[4:0]] <= time_reg;
      end
    end
  end
  // ==========================================================
  // error indicator
  logic [11:0] blink_cnt_reg;
  logic blink_reg;
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
      err_led <= 1'b0;
    end else begin
      if (tick) begin
        if (blink_cnt_reg == 12'(BLINK_TICKS - 1)) begin
          blink_cnt_reg <= '0;
          blink_reg <= !blink_reg;
        end else begin
          blink_cnt_reg <= blink_cnt_reg + 12'h001;
        end
      end
      // steady for fatal, flashing for nonfatal
      err_led <= f_flag_reg || (nf_flag_reg && blink_reg);
    end
  end
  // ==========================================================
  // axi4-lite read channel, one cycle after address accept
  logic [31:0] rd_val;
  logic [8:0] ra;
  logic [4:0] log_rec;
  logic rd_ok;
  assign ra = s_axi_araddr;
  assign log_rec = 5'((ra - UAEL_ADDR_LOG) / 9'h00c);
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (ra >= UAEL_ADDR_LOG && ra < UAEL_ADDR_LOG + 9'(4 * 3 * UAEL_LOG_DEPTH)
      && ra[1:0] == 2'b00) begin
      case ((ra - UAEL_ADDR_LOG) % 9'h00c)
        9'h000: rd_val = {16'h0000, log_code[log_rec]};
        9'h004: rd_val = {16'h0000, log_info[log_rec]};
        default: rd_val = log_time[log_rec];
      endcase
    end else if (ra >= UAEL_ADDR_FLAGS && ra < UAEL_ADDR_LOG &&
      ra[1:0] == 2'b00) begin
      rd_val = executed_alarm_number_flags_reg[
        {ra[5:2], 5'h00} +: 32];
    end else begin
      case (ra)
        UAEL_ADDR_CMD: rd_val = 32'h0000_0000;
        UAEL_ADDR_CTRL: rd_val = {16'h0000, ctrl_reg};
        UAEL_ADDR_STATUS: rd_val = {27'h0, fpd_state_reg == UAEL_FPD_RUN,
          fpd_carry, prog_halt, f_flag_reg, nf_flag_reg};
        UAEL_ADDR_ERR_CODE: rd_val = {16'h0000, error_code_word_reg};
        UAEL_ADDR_LOG_PTR: rd_val = {16'h0000, error_log_pointer_reg};
        UAEL_ADDR_SIM_NUM: rd_val = {16'h0000, simulation_alarm_number_reg};
        UAEL_ADDR_FPD_TIME: rd_val = {16'h0000, fpd_time_reg};
        UAEL_ADDR_FPD_CFG: rd_val = fpd_cfg_reg;
        UAEL_ADDR_DIAG: rd_val = {16'h0000, diag_addr_reg};
        UAEL_ADDR_SYSERR: rd_val = syserr_reg;
        default: rd_ok = 1'b0;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
endmodule
`default_nettype wire

/* File: verification/uael_logger_properties.sv */
// port-level checker for the alarm logger, bound to the design top
`default_nettype none
module uael_logger_props
  import uael_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [8:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic diag_out,
  input wire logic err_led,
  input wire logic prog_halt,
  input wire logic fpd_carry
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ========
  // command detection: only same-edge address and data are tracked
  logic cmd_w;
  assign cmd_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && s_axi_awaddr == UAEL_ADDR_CMD && s_axi_wstrb == 4'hf;
  // ========
  // bus handshake
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped early");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  AST_AR_STALL: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while a read is pending");
  AST_BRESP_OK: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
  AST_RVALID_CAUSE: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid && s_axi_arready)) else $error("stray read data");
  // ========
  // alarm outputs
  AST_FATAL_HALT: assert property (
    cmd_w && s_axi_wdata[UAEL_CMD_FATAL] && !s_axi_wdata[UAEL_CMD_CLEAR]
    |-> ##[1:3] prog_halt) else $error("fatal alarm did not halt");
  AST_NF_NO_HALT: assert property (
    cmd_w && s_axi_wdata[UAEL_CMD_NONFATAL] && !prog_halt &&
    !s_axi_wdata[UAEL_CMD_FATAL] |=> !prog_halt [*3])
    else $error("non-fatal alarm halted execution");
  AST_CLEAR_HALT: assert property (
    cmd_w && s_axi_wdata[UAEL_CMD_CLEAR] && !s_axi_wdata[UAEL_CMD_FATAL]
    |-> ##[1:3] !prog_halt) else $error("clear left halt set");
  AST_LED_STEADY: assert property (prog_halt [*2] |-> err_led)
    else $error("indicator not steady under fatal alarm");
  AST_CARRY_START: assert property (
    cmd_w && s_axi_wdata[UAEL_CMD_FPD_START] |-> ##[1:3] !fpd_carry)
    else $error("carry not cleared by a new start");
  AST_CARRY_CAUSE: assert property (
    $rose(fpd_carry) |-> !$past(diag_out, 3))
    else $error("carry raised with diagnostic output on");
  COV_HALT: cover property ($rose(prog_halt));
  COV_CARRY: cover property ($rose(fpd_carry));
  COV_BLINK: cover property (!prog_halt && $fell(err_led));
endmodule
bind uael_logger uael_logger_props chk (
  .ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .diag_out(diag_out), .err_led(err_led), .prog_halt(prog_halt),
  .fpd_carry(fpd_carry)
);
`default_nettype wire

/* File: verification/uael_diag_src.sv */
// far-side model: plant logic feeding the diagnostic output
`default_nettype none
module uael_diag_src #(
  parameter int BLK = 4
) (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [15:0] dly,
  output logic diag_out,
  output logic [15:0] diag_inputs
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  logic on = 1'h0;
  // one input stays low as the only culprit; delay zero never turns on
  assign diag_out = on;
  assign diag_inputs = on ? 16'hffff : ~(16'h1 << BLK);
  always @(posedge ref_clk) begin
    if (go) begin
      cnt <= 0;
      on <= 1'h0;
    end else if (dly != 16'h0 && !on) begin
      cnt <= cnt + 1;
      on <= (cnt + 1 >= dly);
    end
  end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the user alarm error logger
`default_nettype none
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("wrong value %s exp %h got %h", nm, e, g); \
  end end
module testbench
  import uael_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] NF = 32'h1 << UAEL_CMD_NONFATAL;
  localparam logic [31:0] FT = 32'h1 << UAEL_CMD_FATAL;
  localparam logic [31:0] CL = 32'h1 << UAEL_CMD_CLEAR;
  localparam logic [31:0] GO = 32'h1 << UAEL_CMD_FPD_START;
  typedef struct {
    logic [8:0] a;
    logic w;
    logic [31:0] d;
    logic [15:0] e;
    logic [1:0] r;
  } uael_row_t;
  uael_row_t rows[8] = '{
    '{UAEL_ADDR_STATUS, 1'h0, 32'h0, 16'h0, 2'h0},
    '{UAEL_ADDR_LOG_PTR, 1'h0, 32'h0, 16'h0, 2'h0},
    '{UAEL_ADDR_ERR_CODE, 1'h0, 32'h0, 16'h0, 2'h0},
    '{UAEL_ADDR_FPD_TIME, 1'h0, 32'h0, UAEL_FPD_TIME_RESET, 2'h0},
    '{UAEL_ADDR_LOG_PTR, 1'h1, 32'hff, 16'h0, 2'h0},
    '{UAEL_ADDR_SIM_NUM, 1'h1, 32'h5, 16'h5, 2'h0},
    '{UAEL_ADDR_FPD_TIME, 1'h1, 32'h2, 16'h2, 2'h0},
    '{9'h03c, 1'h0, 32'h0, 16'h0, 2'h2}
  };
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic [8:0] awaddr = 9'h000, araddr = 9'h000;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, ps_go = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [15:0] ps_dly = 16'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic diag_out, led, halt, carry;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [15:0] diag_in;
  int err_count = 0, checked = 0;
  uael_logger #(.BLINK_TICKS(2)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .diag_out(diag_out), .diag_inputs(diag_in),
    .err_led(led), .prog_halt(halt), .fpd_carry(carry));
  uael_diag_src src (.ref_clk(ref_clk), .go(ps_go), .dly(ps_dly),
    .diag_out(diag_out), .diag_inputs(diag_in));
  always #50 ref_clk = ~ref_clk;
  // ========
  // bus tasks: ready is read settled at the falling edge, acted on at rise
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic hang(string nm);
    err_count++;
    $display("wrong value %s exp done got timeout", nm);
    results();
  endtask
  task automatic wr(logic [8:0] a, logic [31:0] d);
    logic at, wt, bt;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int i = 0; i < 50; i++) begin
      @(negedge ref_clk);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid;
      @(posedge ref_clk);
      if (at) awvalid <= 1'h0;
      if (wt) wvalid <= 1'h0;
      if (bt) begin
        bready <= 1'h0;
        return;
      end
    end
    hang("write response");
  endtask
  task automatic rdw(logic [8:0] a);
    logic at, v;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int i = 0; i < 50; i++) begin
      @(negedge ref_clk);
      at = arvalid && arready;
      v = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge ref_clk);
      if (at) arvalid <= 1'h0;
      if (v) begin
        rready <= 1'h0;
        return;
      end
    end
    hang("read data");
  endtask
  task automatic ck(string nm, logic [8:0] a, logic [15:0] e);
    rdw(a);
    `CHK(nm, e, rd[15:0])
  endtask
  task automatic fpd(logic [15:0] dl);
    @(posedge ref_clk);
    ps_dly <= dl;
    ps_go <= 1'h1;
    @(posedge ref_clk);
    ps_go <= 1'h0;
    wr(UAEL_ADDR_CMD, GO);
  endtask
  // ========
  // main sequence
  initial begin
    int lo, hi, k;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'h1;
    repeat (5) @(posedge ref_clk);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rdw(rows[i].a);
      `CHK("row data", rows[i].e, rd[15:0])
      `CHK("row resp", rows[i].r, rs)
    end
    $display("test register table done");
    wr(UAEL_ADDR_CMD, NF | 32'h2);
    ck("nf status", UAEL_ADDR_STATUS, 16'h1);
    ck("code", UAEL_ADDR_ERR_CODE, UAEL_CODE_NONFATAL_BASE | 16'h2);
    ck("num flags", UAEL_ADDR_FLAGS, 16'h4);
    ck("pointer", UAEL_ADDR_LOG_PTR, 16'h1);
    ck("log code", UAEL_ADDR_LOG, 16'h4102);
    lo = 0;
    hi = 0;
    repeat (5000) begin
      @(negedge ref_clk);
      if (led === 1'h1) hi++;
      else lo++;
    end
    `CHK("blink", 1'h1, hi > 500 && lo > 500)
    wr(UAEL_ADDR_CMD, NF);
    ck("nf clear", UAEL_ADDR_STATUS, 16'h0);
    $display("test non-fatal alarm done");
    wr(UAEL_ADDR_CMD, FT | 32'h3);
    ck("fatal status", UAEL_ADDR_STATUS, 16'h6);
    ck("code", UAEL_ADDR_ERR_CODE, UAEL_CODE_FATAL_BASE | 16'h3);
    lo = 0;
    repeat (3000) begin
      @(negedge ref_clk);
      lo += (led !== 1'h1);
    end
    `CHK("steady", 0, lo)
    wr(UAEL_ADDR_CMD, CL);
    ck("cleared", UAEL_ADDR_STATUS, 16'h0);
    ck("num flags", UAEL_ADDR_FLAGS, 16'h0);
    $display("test fatal alarm done");
    wr(UAEL_ADDR_CTRL, 32'h8000);
    wr(UAEL_ADDR_CMD, NF | 32'h7);
    ck("code", UAEL_ADDR_ERR_CODE, 16'h4107);
    ck("nf status", UAEL_ADDR_STATUS, 16'h1);
    ck("num flags", UAEL_ADDR_FLAGS, 16'h80);
    ck("pointer", UAEL_ADDR_LOG_PTR, 16'h2);
    wr(UAEL_ADDR_SYSERR, 32'h80f1_00f1);
    wr(UAEL_ADDR_CMD, NF | 32'h5);
    ck("sim code", UAEL_ADDR_ERR_CODE, 16'h00f1);
    ck("pointer", UAEL_ADDR_LOG_PTR, 16'h3);
    wr(UAEL_ADDR_SIM_NUM, 32'h1ff);
    wr(UAEL_ADDR_CMD, FT | 32'h1ff);
    ck("sim code", UAEL_ADDR_ERR_CODE, 16'h80f1);
    ck("pointer", UAEL_ADDR_LOG_PTR, 16'h4);
    wr(UAEL_ADDR_CMD, CL);
    ck("sim cleared", UAEL_ADDR_STATUS, 16'h0);
    wr(UAEL_ADDR_CTRL, 32'h0);
    $display("test log suppression and simulation done");
    wr(UAEL_ADDR_CTRL, 32'h1);
    ck("ptr reset", UAEL_ADDR_LOG_PTR, 16'h0);
    for (int n = 1; n <= 21; n++) wr(UAEL_ADDR_CMD, NF | n);
    ck("ptr stop", UAEL_ADDR_LOG_PTR, 16'h14);
    ck("oldest", UAEL_ADDR_LOG, 16'h4102);
    ck("second", UAEL_ADDR_LOG + 9'h00c, 16'h4103);
    wr(UAEL_ADDR_CMD, CL);
    $display("test log overflow done");
    wr(UAEL_ADDR_FPD_CFG, 32'h1_0004);
    fpd(16'h0);
    for (k = 0; k < 6000 && carry !== 1'h1; k++) @(negedge ref_clk);
    if (carry !== 1'h1) hang("carry");
    `CHK("carry time", 1'h1, k > 900)
    ck("fpd status", UAEL_ADDR_STATUS, 16'h9);
    ck("fpd code", UAEL_ADDR_ERR_CODE, 16'h4104);
    ck("blocking bit", UAEL_ADDR_DIAG, 16'h4);
    wr(UAEL_ADDR_CMD, CL);
    fpd(16'h1f4);
    repeat (4000) @(negedge ref_clk);
    `CHK("no carry", 1'h0, carry)
    wr(UAEL_ADDR_CTRL, 32'h2);
    fpd(16'hbea);
    repeat (5000) @(negedge ref_clk);
    rdw(UAEL_ADDR_FPD_TIME);
    `CHK("taught", 1'h1, rd[15:0] >= 16'h3 && rd[15:0] <= 16'h4)
    `CHK("teach carry", 1'h0, carry)
    $display("test failure point detection done");
    wr(UAEL_ADDR_CMD, FT | 32'h9);
    nrst <= 1'h0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'h1;
    repeat (5) @(posedge ref_clk);
    `CHK("reset halt", 1'h0, halt)
    ck("reset status", UAEL_ADDR_STATUS, 16'h0);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
